// file: hdl/iaf_flags.sv
// Address match and arbitration-lost status flags of a two-wire bus port
//
// The address-and-strobe port and the address map were decided locally.
`default_nettype none

module iaf_flags
  import iaf_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  // Register port
  input  wire logic [IAF_ADDR_W-1:0] reg_addr_i,
  input  wire logic [IAF_DATA_W-1:0] reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [IAF_DATA_W-1:0] reg_rdata_o,
  // Bus pins, asynchronous
  input  wire logic                  scl_i,
  input  wire logic                  sda_i,
  // Controller state, same clock
  input  wire logic                  master_mode_i,
  input  wire logic                  transmit_mode_i,
  input  wire logic                  sda_drive_i,
  input  wire logic                  start_request_i,
  input  wire logic                  tx_data_empty_i,
  input  wire logic                  rx_data_full_i,
  // Outputs
  output logic      [7:0]            bus_status_flags_o,
  output logic                       irq_o
);

  // Widths the decode and flag layout rely on, refused at elaboration
  if (IAF_DATA_W != 8 || IAF_ADDR_W < 3) begin : g_geom_chk
    $error("iaf_flags: unsupported bus geometry");
  end

  // Pin synchronisers; stage one feeds only stage two
  logic scl_m_reg, scl_s_reg, scl_q_reg;
  logic sda_m_reg, sda_s_reg, sda_q_reg;

  // Frame receiver state
  logic [7:0]  frame_reg;        // Shifted-in bits
  logic [3:0]  bit_cnt_reg;      // Bits taken since start
  logic        first_frame_reg;  // Awaiting the address frame
  logic        start_pend_reg;   // Start requested, line not yet low
  logic        master_q_reg;     // Previous master mode
  logic        tx_empty_q_reg;   // Previous transmit-empty level
  logic        rx_full_q_reg;    // Previous receive-full level

  // Software registers and flags
  logic [7:0]  own_addr_reg;     // own_slave_addr_reg
  logic [7:0]  sec_addr_reg;     // second_slave_addr_reg
  logic [7:0]  flags_reg;        // bus_status_flags
  logic [7:0]  armed_reg;        // Flags read as one since last set
  logic [5:0]  irq_stat_reg;     // Sticky events
  logic [5:0]  irq_mask_reg;     // Event enables
  logic [7:0]  flags_next;
  logic [7:0]  armed_next;
  logic [5:0]  irq_stat_next;

  // Decode of a register address
  function automatic logic hit(input logic [IAF_ADDR_W-1:0] a,
                               input logic [3:0] ofs);
    hit = (a == IAF_ADDR_W'(ofs));
  endfunction

  // Register strobes
  wire wr_status = reg_wr_i & hit(reg_addr_i, IAF_OFS_STATUS);
  wire rd_status = reg_rd_i & hit(reg_addr_i, IAF_OFS_STATUS);
  wire wr_own    = reg_wr_i & hit(reg_addr_i, IAF_OFS_OWN_ADDR);
  wire wr_sec    = reg_wr_i & hit(reg_addr_i, IAF_OFS_SEC_ADDR);
  wire wr_data   = reg_wr_i & hit(reg_addr_i, IAF_OFS_DATA);
  wire rd_data   = reg_rd_i & hit(reg_addr_i, IAF_OFS_DATA);
  wire wr_istat  = reg_wr_i & hit(reg_addr_i, IAF_OFS_IRQ_STAT);
  wire wr_imask  = reg_wr_i & hit(reg_addr_i, IAF_OFS_IRQ_MASK);

  // Line events seen by the core clock, and master mode entry
  wire scl_rise  = scl_s_reg & ~scl_q_reg;
  wire start_det = scl_s_reg & scl_q_reg & ~sda_s_reg & sda_q_reg;
  wire stop_det  = scl_s_reg & scl_q_reg & sda_s_reg & ~sda_q_reg;
  wire master_in = master_mode_i & ~master_q_reg;

  // Address frame complete in slave receive mode
  wire [7:0] frame_full = {frame_reg[6:0], sda_s_reg};
  wire frame_done = first_frame_reg & scl_rise &
                    (bit_cnt_reg == IAF_FRAME_BITS - 4'h1);
  wire slave_rx   = ~master_mode_i & ~transmit_mode_i;
  wire addr_eval  = frame_done & slave_rx;
  wire fs         = own_addr_reg[IAF_BIT_FMT];
  wire second_format_select        = sec_addr_reg[IAF_BIT_FMT];
  wire is_gc      = (frame_full == IAF_GEN_CALL);
  wire own_hit    = (frame_full[7:1] == own_addr_reg[7:IAF_ADR_LSB]);
  wire sec_hit    = (frame_full[7:1] == sec_addr_reg[7:IAF_ADR_LSB]);

  // Set conditions of each flag
  wire set_sec = addr_eval & ~second_format_select & sec_hit & ~is_gc;
  wire set_own = addr_eval & ~fs & (own_hit | is_gc);
  wire set_gc  = addr_eval & (~fs | ~second_format_select) & is_gc;
  wire al_bit  = master_mode_i & transmit_mode_i & scl_rise &
                 (sda_drive_i != sda_s_reg);
  wire al_start = start_pend_reg & sda_drive_i & ~sda_s_reg;
  wire set_al  = al_bit | al_start;
  wire data_rise = (tx_data_empty_i & ~tx_empty_q_reg) |
                   (rx_data_full_i & ~rx_full_q_reg);
  wire set_cx  = data_rise &
                 (master_mode_i | flags_reg[IAF_BIT_SEC]);

  // Data register access that clears the arbitration, own address and general call flags
  wire data_clr = (wr_data & transmit_mode_i) |
                  (rd_data & ~transmit_mode_i);

  // Software clear: written zero on a bit that was read as one
  wire [7:0] sw_clr = {8{wr_status}} & ~reg_wdata_i & armed_reg;

  // Hardware set vector in flag layout
  wire [7:0] hw_set;
  assign hw_set[IAF_BIT_CX]  = set_cx;
  assign hw_set[IAF_BIT_SEC] = set_sec;
  assign hw_set[IAF_BIT_AL]  = set_al;
  assign hw_set[IAF_BIT_OWN] = set_own;
  assign hw_set[IAF_BIT_GC]  = set_gc;
  assign hw_set[7:6]         = 2'h0;
  assign hw_set[0]           = 1'b0;

  // Hardware clear vector in flag layout
  wire [7:0] hw_clr;
  assign hw_clr[IAF_BIT_CX]  = 1'b0;
  assign hw_clr[IAF_BIT_SEC] = start_det | master_in;
  assign hw_clr[IAF_BIT_AL]  = data_clr;
  assign hw_clr[IAF_BIT_OWN] = data_clr | master_in;
  assign hw_clr[IAF_BIT_GC]  = data_clr | master_in;
  assign hw_clr[7:6]         = 2'h0;
  assign hw_clr[0]           = 1'b0;

  // Flag update; set wins over every clear
  always_comb begin
    flags_next = (flags_reg & ~(sw_clr | hw_clr)) | hw_set;
    armed_next = armed_reg & ~(sw_clr | hw_clr | hw_set);
    if (rd_status) begin
      armed_next = armed_next | (flags_reg & ~hw_set);
    end
  end

  // Event vector for the sticky interrupt status
  wire [5:0] events = {set_cx, set_sec, set_al, set_own, set_gc,
                       stop_det};

  // Interrupt status: events set, written ones clear, set wins
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_istat) begin
      irq_stat_next = irq_stat_next & ~reg_wdata_i[5:0];
    end
    irq_stat_next = irq_stat_next | events;
  end

  // Read data selection
  wire [7:0] rd_mux =
    hit(reg_addr_i, IAF_OFS_STATUS)   ? flags_reg :
    hit(reg_addr_i, IAF_OFS_OWN_ADDR) ? own_addr_reg :
    hit(reg_addr_i, IAF_OFS_SEC_ADDR) ? sec_addr_reg :
    hit(reg_addr_i, IAF_OFS_DATA)     ? frame_reg :
    hit(reg_addr_i, IAF_OFS_IRQ_STAT) ? {2'h0, irq_stat_reg} :
    hit(reg_addr_i, IAF_OFS_IRQ_MASK) ? {2'h0, irq_mask_reg} :
    8'h00;

  // Two-flop synchronisers and edge history for the pins
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      {scl_m_reg, scl_s_reg, scl_q_reg} <= 3'h7;
      {sda_m_reg, sda_s_reg, sda_q_reg} <= 3'h7;
    end else begin
      {scl_m_reg, scl_s_reg, scl_q_reg} <= {scl_i, scl_m_reg, scl_s_reg};
      {sda_m_reg, sda_s_reg, sda_q_reg} <= {sda_i, sda_m_reg, sda_s_reg};
    end
  end

  // Address frame shifter: armed by start, closed after eight bits
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      frame_reg       <= 8'h00;
      bit_cnt_reg     <= 4'h0;
      first_frame_reg <= 1'b0;
    end else if (start_det) begin
      bit_cnt_reg     <= 4'h0;
      first_frame_reg <= 1'b1;
    end else if (stop_det || frame_done) begin
      if (frame_done) begin
        frame_reg <= frame_full;
      end
      first_frame_reg <= 1'b0;
    end else if (first_frame_reg && scl_rise) begin
      frame_reg   <= frame_full;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Start request window: open until either side pulls the line low or master mode ends
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      start_pend_reg <= 1'b0;
    end else if (start_request_i && master_mode_i && transmit_mode_i) begin
      start_pend_reg <= 1'b1;
    end else if (!sda_drive_i || al_start || !master_mode_i) begin
      start_pend_reg <= 1'b0;
    end
  end

  // Level history for rising-edge detection of same-clock inputs
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      master_q_reg   <= 1'b0;
      tx_empty_q_reg <= 1'b0;
      rx_full_q_reg  <= 1'b0;
    end else begin
      master_q_reg   <= master_mode_i;
      tx_empty_q_reg <= tx_data_empty_i;
      rx_full_q_reg  <= rx_data_full_i;
    end
  end

  // Address, format and interrupt mask registers written by software
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      own_addr_reg <= IAF_RST_ADDR;
      sec_addr_reg <= IAF_RST_ADDR;
      irq_mask_reg <= IAF_RST_MASK;
    end else begin
      if (wr_own) begin
        own_addr_reg <= reg_wdata_i;
      end
      if (wr_sec) begin
        sec_addr_reg <= reg_wdata_i;
      end
      if (wr_imask) begin
        irq_mask_reg <= reg_wdata_i[5:0];
      end
    end
  end

  // Flags, arming bits and interrupt status
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      flags_reg    <= IAF_RST_STATUS;
      armed_reg    <= 8'h00;
      irq_stat_reg <= 6'h00;
    end else begin
      flags_reg    <= flags_next;
      armed_reg    <= armed_next;
      irq_stat_reg <= irq_stat_next;
    end
  end

  // Registered outputs: read data, flag copy, interrupt level
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o        <= 8'h00;
      bus_status_flags_o <= IAF_RST_STATUS;
      irq_o              <= 1'b0;
    end else begin
      reg_rdata_o        <= reg_rd_i ? rd_mux : 8'h00;
      bus_status_flags_o <= flags_next;
      irq_o              <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // Assertions guarding the flag behaviour
  property p_sec_set;
    @(posedge core_clk_i) disable iff (!rstn_i)
      set_sec |=> flags_reg[IAF_BIT_SEC];
  endproperty
  a_sec_set: assert property (p_sec_set)
    else $error("second address flag not set on match");

  property p_sec_cmp;
    @(posedge core_clk_i) disable iff (!rstn_i)
      addr_eval && !second_format_select && !is_gc &&
      frame_full[7:1] == sec_addr_reg[7:1] |=> flags_reg[IAF_BIT_SEC];
  endproperty
  a_sec_cmp: assert property (p_sec_cmp)
    else $error("second address compare missed");

  property p_sw_clear;
    @(posedge core_clk_i) disable iff (!rstn_i)
      wr_status && !reg_wdata_i[IAF_BIT_AL] && armed_reg[IAF_BIT_AL] &&
      !set_al |=> !flags_reg[IAF_BIT_AL];
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("arbitration flag not cleared by zero");

  property p_sec_start_clr;
    @(posedge core_clk_i) disable iff (!rstn_i)
      (start_det || master_in) && !set_sec |=> !flags_reg[IAF_BIT_SEC];
  endproperty
  a_sec_start_clr: assert property (p_sec_start_clr)
    else $error("second address flag survived start");

  property p_al_bit;
    @(posedge core_clk_i) disable iff (!rstn_i)
      master_mode_i && transmit_mode_i && scl_rise &&
      sda_drive_i && !sda_s_reg |=> flags_reg[IAF_BIT_AL];
  endproperty
  a_al_bit: assert property (p_al_bit)
    else $error("arbitration loss not flagged");

  property p_data_clr;
    @(posedge core_clk_i) disable iff (!rstn_i)
      rd_data && !transmit_mode_i && !set_own && !set_gc |=>
      !flags_reg[IAF_BIT_OWN] && !flags_reg[IAF_BIT_GC];
  endproperty
  a_data_clr: assert property (p_data_clr)
    else $error("data read did not clear flags");

  property p_fmt_one;
    @(posedge core_clk_i) disable iff (!rstn_i)
      addr_eval && fs && !second_format_select && is_gc |=>
      flags_reg[IAF_BIT_GC] && $stable(flags_reg[IAF_BIT_OWN]);
  endproperty
  a_fmt_one: assert property (p_fmt_one)
    else $error("general call handling with primary format one");

  property p_write_one;
    @(posedge core_clk_i) disable iff (!rstn_i)
      wr_status && reg_wdata_i[IAF_BIT_GC] && !data_clr && !master_in &&
      flags_reg[IAF_BIT_GC] |=> flags_reg[IAF_BIT_GC];
  endproperty
  a_write_one: assert property (p_write_one)
    else $error("written one changed a flag");

  property p_cx;
    @(posedge core_clk_i) disable iff (!rstn_i)
      flags_reg[IAF_BIT_SEC] &&
      ($rose(rx_data_full_i) || $rose(tx_data_empty_i)) |=>
      flags_reg[IAF_BIT_CX] ##1 (irq_o || !irq_mask_reg[IAF_BIT_CX]);
  endproperty
  a_cx: assert property (p_cx)
    else $error("continuous transfer flag not raised");

  property p_own_master;
    @(posedge core_clk_i) disable iff (!rstn_i)
      master_in |=> !flags_reg[IAF_BIT_OWN];
  endproperty
  a_own_master: assert property (p_own_master)
    else $error("own address flag survived master entry");

  // Coverage of the main scenarios
  c_own: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    set_own ##[1:50] data_clr);
  c_al_start: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    al_start);
  c_gc: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    set_gc && !set_own);
  c_sec_cx: cover property (@(posedge core_clk_i) disable iff (!rstn_i)
    set_sec ##[1:400] set_cx);

endmodule

`default_nettype wire

// file: hdl/iaf_pkg.sv
// Constants for the address and arbitration status flag block
`default_nettype none

package iaf_pkg;

  // Register bus geometry
  localparam int unsigned IAF_ADDR_W = 4;
  localparam int unsigned IAF_DATA_W = 8;

  // Register offsets
  localparam logic [3:0] IAF_OFS_STATUS   = 4'h0; // bus_status_flags
  localparam logic [3:0] IAF_OFS_OWN_ADDR = 4'h1; // own_slave_addr_reg
  localparam logic [3:0] IAF_OFS_SEC_ADDR = 4'h2; // second_slave_addr_reg
  localparam logic [3:0] IAF_OFS_DATA     = 4'h3; // bus_data_reg
  localparam logic [3:0] IAF_OFS_IRQ_STAT = 4'h4; // Sticky event bits
  localparam logic [3:0] IAF_OFS_IRQ_MASK = 4'h5; // Event enables

  // Field positions in bus_status_flags
  localparam int unsigned IAF_BIT_CX  = 5; // continuous_xfer_irq_flag
  localparam int unsigned IAF_BIT_SEC = 4; // second_addr_match_flag
  localparam int unsigned IAF_BIT_AL  = 3; // arbitration_lost_flag
  localparam int unsigned IAF_BIT_OWN = 2; // own_addr_match_flag
  localparam int unsigned IAF_BIT_GC  = 1; // general_call_flag

  // Field positions in the address registers
  localparam int unsigned IAF_BIT_FMT = 0; // Format select bit
  localparam int unsigned IAF_ADR_LSB = 1; // Address bit0 position

  // Field positions in the interrupt status and mask registers
  localparam int unsigned IAF_EV_W    = 6;
  localparam int unsigned IAF_EV_STOP = 0; // Stop condition seen

  // Reset values
  localparam logic [7:0] IAF_RST_STATUS = 8'h00;
  localparam logic [7:0] IAF_RST_ADDR   = 8'h00;
  localparam logic [5:0] IAF_RST_MASK   = 6'h00;

  // General call frame value and frame length
  localparam logic [7:0] IAF_GEN_CALL   = 8'h00;
  localparam logic [3:0] IAF_FRAME_BITS = 4'h8;

endpackage

`default_nettype wire

// file: sim/iaf_flags_tb.sv
// Self-checking bench for the address and arbitration status flags
`default_nettype none

module iaf_flags_tb;
  import iaf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // Design stimulus and observation
  logic                  core_clk_i, rstn_i;
  logic [IAF_ADDR_W-1:0] reg_addr_i;
  logic [IAF_DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  logic                  reg_wr_i, reg_rd_i, scl_i, sda_i;
  logic                  master_mode_i, transmit_mode_i, sda_drive_i;
  logic                  start_request_i, tx_data_empty_i, rx_data_full_i;
  logic [7:0]            bus_status_flags_o;
  logic                  irq_o;
  // Scoreboard state
  logic [7:0]            exp_q[$];
  logic                  rd_seen = 1'b0;
  int                    bad_count = 0;
  int                    total_checks = 0;
  logic [31:0]           seed;
  logic [6:0]            own_a, sec_a;

  iaf_flags i_dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .sda_i(sda_i),
    .master_mode_i(master_mode_i), .transmit_mode_i(transmit_mode_i),
    .sda_drive_i(sda_drive_i), .start_request_i(start_request_i),
    .tx_data_empty_i(tx_data_empty_i), .rx_data_full_i(rx_data_full_i),
    .bus_status_flags_o(bus_status_flags_o), .irq_o(irq_o));

  iaf_peer i_peer (.scl_o(scl_i), .sda_o(sda_i));

  // 100 MHz core clock
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // Pseudo-random source for the programmed addresses
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Compare one seen value against its expectation
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Read data stand in the cycle after the strobe: match oldest note
  always @(posedge core_clk_i) begin
    if (rd_seen && exp_q.size() > 0) begin
      check(reg_rdata_o, exp_q.pop_front());
    end
    rd_seen <= reg_rd_i;
  end

  // One-cycle write on the register port
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  // One-cycle read; expected value noted for the monitor
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
  endtask

  // Let registered flags and the interrupt settle
  task automatic settle();
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask

  // Whole frame from the far side, then settle
  task automatic frame(input logic [7:0] f);
    i_peer.send_frame(f);
    settle();
  endtask

  // Controller mode change
  task automatic mode(input logic m, input logic t);
    @(posedge core_clk_i);
    master_mode_i   <= m;
    transmit_mode_i <= t;
    settle();
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    #200us;
    bad_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    rstn_i = 1'b0;
    reg_addr_i = 4'h0;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    master_mode_i = 1'b0;
    transmit_mode_i = 1'b0;
    sda_drive_i = 1'b0;
    start_request_i = 1'b0;
    tx_data_empty_i = 1'b0;
    rx_data_full_i = 1'b0;
    seed = lfsr(32'hcee1);
    own_a = {1'b1, seed[5:0]};
    sec_a = {1'b0, seed[13:8]} | 7'h01;
    repeat (20) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    // Reset values, unmapped place, address programming
    rd(IAF_OFS_STATUS, IAF_RST_STATUS);
    rd(IAF_OFS_OWN_ADDR, IAF_RST_ADDR);
    rd(IAF_OFS_IRQ_MASK, {2'b00, IAF_RST_MASK});
    wr(4'h9, 8'hff);
    rd(4'h9, 8'h00);
    wr(IAF_OFS_OWN_ADDR, {own_a, 1'b0});
    wr(IAF_OFS_SEC_ADDR, {sec_a, 1'b0});
    rd(IAF_OFS_SEC_ADDR, {sec_a, 1'b0});
    // Own address match, written one ignored, zero clears
    frame({own_a, 1'b0});
    check(bus_status_flags_o, 8'h04);
    rd(IAF_OFS_STATUS, 8'h04);
    wr(IAF_OFS_STATUS, 8'hff);
    rd(IAF_OFS_STATUS, 8'h04);
    wr(IAF_OFS_STATUS, 8'h00);
    rd(IAF_OFS_STATUS, 8'h00);
    frame({own_a, 1'b1});
    rd(IAF_OFS_STATUS, 8'h04);
    mode(1'b1, 1'b0);
    rd(IAF_OFS_STATUS, 8'h00);
    mode(1'b0, 1'b0);
    // Second address match and its clearing paths
    frame({sec_a, 1'b0});
    wr(IAF_OFS_STATUS, 8'h00);
    rd(IAF_OFS_STATUS, 8'h10);
    wr(IAF_OFS_STATUS, 8'h00);
    rd(IAF_OFS_STATUS, 8'h00);
    frame({sec_a, 1'b1});
    rd(IAF_OFS_STATUS, 8'h10);
    frame({own_a ^ 7'h01, 1'b1});
    rd(IAF_OFS_STATUS, 8'h00);
    frame({sec_a, 1'b0});
    mode(1'b1, 1'b0);
    rd(IAF_OFS_STATUS, 8'h00);
    mode(1'b0, 1'b0);
    // General call with both formats 0, then primary format 1
    frame(IAF_GEN_CALL);
    check(bus_status_flags_o, 8'h06);
    wr(IAF_OFS_STATUS, 8'hff);
    rd(IAF_OFS_STATUS, 8'h06);
    rd(IAF_OFS_DATA, IAF_GEN_CALL);
    rd(IAF_OFS_STATUS, 8'h00);
    wr(IAF_OFS_OWN_ADDR, {own_a, 1'b1});
    frame(IAF_GEN_CALL);
    rd(IAF_OFS_STATUS, 8'h02);
    mode(1'b1, 1'b0);
    rd(IAF_OFS_STATUS, 8'h00);
    mode(1'b0, 1'b0);
    // Continuous transfer flag and the interrupt path
    frame({sec_a, 1'b0});
    wr(IAF_OFS_IRQ_STAT, 8'h3f);
    wr(IAF_OFS_IRQ_MASK, 8'h20);
    @(posedge core_clk_i);
    tx_data_empty_i <= 1'b1;
    settle();
    rd(IAF_OFS_STATUS, 8'h30);
    rd(IAF_OFS_IRQ_STAT, 8'h20);
    settle();
    check({7'h00, irq_o}, 8'h01);
    wr(IAF_OFS_IRQ_MASK, 8'h00);
    settle();
    check({7'h00, irq_o}, 8'h00);
    wr(IAF_OFS_IRQ_MASK, 8'h20);
    settle();
    check({7'h00, irq_o}, 8'h01);
    wr(IAF_OFS_IRQ_STAT, 8'h20);
    settle();
    check({7'h00, irq_o}, 8'h00);
    // Receive-full rising edge with the second match still set
    @(posedge core_clk_i);
    rx_data_full_i <= 1'b1;
    settle();
    check({7'h00, irq_o}, 8'h01);
    check(bus_status_flags_o, 8'h30);
    rd(IAF_OFS_STATUS, 8'h30);
    wr(IAF_OFS_STATUS, 8'h00);
    tx_data_empty_i <= 1'b0;
    rx_data_full_i  <= 1'b0;
    // Arbitration loss in master transmit, driving high
    sda_drive_i <= 1'b1;
    mode(1'b1, 1'b1);
    rd(IAF_OFS_STATUS, 8'h00);
    i_peer.pull_low();
    settle();
    rd(IAF_OFS_STATUS, 8'h00);
    @(posedge core_clk_i);
    start_request_i <= 1'b1;
    @(posedge core_clk_i);
    start_request_i <= 1'b0;
    i_peer.pull_low();
    settle();
    check(bus_status_flags_o, 8'h08);
    rd(IAF_OFS_STATUS, 8'h08);
    wr(IAF_OFS_DATA, 8'h5a);
    rd(IAF_OFS_STATUS, 8'h00);
    frame(8'h00);
    check(bus_status_flags_o, 8'h08);
    rd(IAF_OFS_STATUS, 8'h08);
    wr(IAF_OFS_STATUS, 8'h00);
    rd(IAF_OFS_STATUS, 8'h00);
    settle();
    stop_test();
  end
endmodule

`default_nettype wire

// file: sim/iaf_peer.sv
// Behavioural far-side bus master driving the two-wire pins
`default_nettype none

module iaf_peer (
  // Pin levels, pulled up while released
  output var logic scl_o,
  output var logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus: both lines released high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Start, eight bits MSB first on an 80 ns link clock, then stop
  task automatic send_frame(input logic [7:0] f);
    sda_o = 1'b0;
    #40;
    scl_o = 1'b0;
    #20;
    for (int i = 7; i >= 0; i--) begin
      sda_o = f[i];
      #20;
      scl_o = 1'b1;
      #40;
      scl_o = 1'b0;
      #20;
    end
    // Stop: data rises while the clock is high
    sda_o = 1'b0;
    #20;
    scl_o = 1'b1;
    #20;
    sda_o = 1'b1;
    #40;
  endtask

  // Pull data low with the clock left high, then release
  task automatic pull_low();
    sda_o = 1'b0;
    #80;
    sda_o = 1'b1;
    #80;
  endtask
endmodule

`default_nettype wire
